// [core/temp_limit_monitor_pkg.sv]
// constants and carriers for the temperature limit monitor
package temp_limit_monitor_pkg;
  // ==========================================================
  // widths
  localparam int NUM_CHAN = 3;
  localparam int TEMP_W   = 12;
  localparam int ADDR_W   = 3;
  localparam int DATA_W   = 16;
  localparam int CFG_W    = 6;
  localparam int DEPTH_W  = 2;
  localparam int CNT_W    = 5;
  localparam int ACC_W    = TEMP_W + CNT_W;
  localparam int NUM_LIMIT = 2 * NUM_CHAN;
  // ==========================================================
  // register map
  localparam logic [ADDR_W-1:0] ADDR_AVG_CFG    = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_LIMIT_BASE = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_LIMIT_LAST = 3'h6;
  // ==========================================================
  // reset values
  localparam logic [CFG_W-1:0]  CFG_RESET        = 6'h00;
  localparam logic [TEMP_W-1:0] HIGH_LIMIT_RESET = 12'h7ff;
  localparam logic [TEMP_W-1:0] LOW_LIMIT_RESET  = 12'h800;
  // ==========================================================
  // field layout
  localparam int FLAG_W        = 3;
  localparam int FLAG_HIGH_BIT = 2;
  localparam int FLAG_LOW_BIT  = 1;
  // averaging depth code 0 means 2**2 samples
  localparam logic [2:0] LOG2_MIN_SAMPLES = 3'h2;

  typedef struct packed {
    logic                     we;
    logic                     re;
    logic [ADDR_W-1:0]        addr;
    logic [DATA_W-1:0]        wdata;
  } reg_req_s;

  typedef struct packed {
    logic signed [TEMP_W-1:0] avg;
    logic [FLAG_W-1:0]        flags;
  } chan_result_s;
endpackage

// [core/temp_limit_monitor.sv]
// temperature averaging and high/low limit monitor for three channels
// Function
// - internal channel averages 4/8/16/32 samples per config bits 1:0.
// - first external channel averages 4/8/16/32 samples per config bits 3:2.
// - second external channel averages 4/8/16/32 samples per config bits 5:4.
// - internal flag bit 2 set when internal average exceeds its high limit.
// - internal flag bit 1 set when internal average falls below its low limit.
// - first external flag bit 2 set when above its high limit.
// - first external flag bit 1 set when below its low limit.
// - second external flag bit 2 set when above its high limit.
// - second external flag bit 1 set when below its low limit.
// - limits are 12-bit two's complement, 0.125 C per lsb, compared signed.
// - each channel measures and monitors only while its enable bit is set.
`timescale 1ns/1ps
`default_nettype none
module temp_limit_monitor
  import temp_limit_monitor_pkg::*;
(
  input  wire logic                             i_core_clk,
  input  wire logic                             i_rst,
  input  wire reg_req_s                         i_reg,
  output logic [DATA_W-1:0]                     o_reg_rdata,
  output logic                                  o_reg_rvalid,
  input  wire logic [NUM_CHAN-1:0]              i_chan_en,
  input  wire logic [NUM_CHAN-1:0]              i_sample_valid,
  input  wire logic [NUM_CHAN-1:0][TEMP_W-1:0]  i_sample,
  output chan_result_s [NUM_CHAN-1:0]           o_result,
  output logic [NUM_CHAN-1:0]                   o_done
);

  // ==========================================================
  // register file
  logic [CFG_W-1:0]  cfg;
  logic [CFG_W-1:0]  next_cfg;
  logic [TEMP_W-1:0] limit      [NUM_LIMIT];
  logic [TEMP_W-1:0] next_limit [NUM_LIMIT];
  logic [DATA_W-1:0] next_rdata;
  logic              next_rvalid;
  logic [ADDR_W-1:0] lim_idx;

  // address 7 lies past the last limit, so writes there drop and reads give zero
  assign lim_idx = i_reg.addr - ADDR_LIMIT_BASE;

  always_comb begin
    next_cfg    = cfg;
    next_limit  = limit;
    next_rdata  = '0;
    next_rvalid = i_reg.re;
    if (i_reg.we) begin
      if (i_reg.addr == ADDR_AVG_CFG) begin
        next_cfg = i_reg.wdata[CFG_W-1:0];
      end else if (i_reg.addr <= ADDR_LIMIT_LAST) begin
        next_limit[lim_idx] = i_reg.wdata[TEMP_W-1:0];
      end
    end
    // unmapped reads return zero; reserved upper bits read zero
    if (i_reg.re) begin
      if (i_reg.addr == ADDR_AVG_CFG) begin
        next_rdata = {{(DATA_W-CFG_W){1'b0}}, cfg};
      end else if (i_reg.addr <= ADDR_LIMIT_LAST) begin
        next_rdata = {{(DATA_W-TEMP_W){1'b0}}, limit[lim_idx]};
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cfg          <= CFG_RESET;
      o_reg_rdata  <= '0;
      o_reg_rvalid <= 1'b0;
      for (int k = 0; k < NUM_LIMIT; k++) begin
        limit[k] <= (k % 2 == 0) ? HIGH_LIMIT_RESET : LOW_LIMIT_RESET;
      end
    end else begin
      cfg          <= next_cfg;
      limit        <= next_limit;
      o_reg_rdata  <= next_rdata;
      o_reg_rvalid <= next_rvalid;
    end
  end

  // ==========================================================
  // per-channel averaging and limit compare
  logic [CNT_W-1:0]        cnt         [NUM_CHAN];
  logic signed [ACC_W-1:0] acc         [NUM_CHAN];
  chan_result_s            next_result [NUM_CHAN];
  logic                    next_done   [NUM_CHAN];

  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
    logic [2:0]               log2n;
    logic                     last;
    logic signed [ACC_W-1:0]  sum;
    logic signed [ACC_W-1:0]  quot;
    logic signed [TEMP_W-1:0] avg_now;
    logic [CNT_W-1:0]         next_cnt;
    logic signed [ACC_W-1:0]  next_acc;

    // three-bit shift so code 3 gives 5, not a wrapped 1
    assign log2n = {1'b0, cfg[DEPTH_W*c +: DEPTH_W]} + LOG2_MIN_SAMPLES;
    // counter stops one short of the depth; the sample at that count closes the block
    assign last  = (cnt[c] == CNT_W'(6'(6'h01 << log2n) - 6'h01));

    always_comb begin
      sum            = acc[c] + ACC_W'($signed(i_sample[c]));
      quot           = sum >>> log2n;
      avg_now        = quot[TEMP_W-1:0];
      next_cnt       = cnt[c];
      next_acc       = acc[c];
      next_result[c] = o_result[c];
      next_done[c]   = 1'b0;
      if (!i_chan_en[c]) begin
        next_cnt             = '0;
        next_acc             = '0;
        next_result[c].flags = '0;
      end else if (i_sample_valid[c]) begin
        if (last) begin
          next_cnt             = '0;
          next_acc             = '0;
          next_done[c]         = 1'b1;
          next_result[c].avg   = avg_now;
          next_result[c].flags = '0;
          // signed compare on 0.125 C codes
          next_result[c].flags[FLAG_HIGH_BIT] = avg_now > $signed(limit[2*c]);
          next_result[c].flags[FLAG_LOW_BIT]  = avg_now < $signed(limit[2*c+1]);
        end else begin
          next_cnt = cnt[c] + CNT_W'(1);
          next_acc = sum;
        end
      end
    end

    always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
        cnt[c] <= '0;
        acc[c] <= '0;
      end else begin
        cnt[c] <= next_cnt;
        acc[c] <= next_acc;
      end
    end
  end

  // ==========================================================
  // result registers
  // one process writes the packed outputs so each bit has a single writer
  always_ff @(posedge i_core_clk) begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (i_rst) begin
        o_result[c] <= '0;
        o_done[c]   <= 1'b0;
      end else begin
        o_result[c] <= next_result[c];
        o_done[c]   <= next_done[c];
      end
    end
  end

  // ==========================================================
  // checks
  // $past picks the depth and limits that stood at the closing sample edge
  int_depth_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_done[0] |-> {1'b0, $past(cnt[0])} ==
      6'(6'(6'h01 << ({1'b0, $past(cfg[1:0])} + LOG2_MIN_SAMPLES)) - 6'h01))
    else $error("internal average used wrong sample count");
  ext1_depth_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_done[1] |-> {1'b0, $past(cnt[1])} ==
      6'(6'(6'h01 << ({1'b0, $past(cfg[3:2])} + LOG2_MIN_SAMPLES)) - 6'h01))
    else $error("ext1 average used wrong sample count");
  ext2_depth_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_done[2] |-> {1'b0, $past(cnt[2])} ==
      6'(6'(6'h01 << ({1'b0, $past(cfg[5:4])} + LOG2_MIN_SAMPLES)) - 6'h01))
    else $error("ext2 average used wrong sample count");
  int_high_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_done[0] |-> o_result[0].flags[FLAG_HIGH_BIT] ==
      (o_result[0].avg > $signed($past(limit[0]))))
    else $error("internal high flag wrong");
  int_low_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_done[0] |-> o_result[0].flags[FLAG_LOW_BIT] ==
      (o_result[0].avg < $signed($past(limit[1]))))
    else $error("internal low flag wrong");
  ext1_high_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_done[1] |-> o_result[1].flags[FLAG_HIGH_BIT] ==
      (o_result[1].avg > $signed($past(limit[2]))))
    else $error("ext1 high flag wrong");
  ext1_low_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_done[1] |-> o_result[1].flags[FLAG_LOW_BIT] ==
      (o_result[1].avg < $signed($past(limit[3]))))
    else $error("ext1 low flag wrong");
  ext2_high_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_done[2] |-> o_result[2].flags[FLAG_HIGH_BIT] ==
      (o_result[2].avg > $signed($past(limit[4]))))
    else $error("ext2 high flag wrong");
  ext2_low_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_done[2] |-> o_result[2].flags[FLAG_LOW_BIT] ==
      (o_result[2].avg < $signed($past(limit[5]))))
    else $error("ext2 low flag wrong");
  chan_off_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_chan_en[1] |=> (o_result[1].flags == '0) && !o_done[1])
    else $error("disabled channel still monitoring");
  int_off_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_chan_en[0] |=> (o_result[0].flags == '0) && !o_done[0])
    else $error("disabled internal channel still monitoring");
  ext2_off_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_chan_en[2] |=> (o_result[2].flags == '0) && !o_done[2])
    else $error("disabled ext2 channel still monitoring");
  int_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $changed(o_result[0].avg) |-> o_done[0])
    else $error("internal average moved without completion");
  ext1_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $changed(o_result[1].avg) |-> o_done[1])
    else $error("ext1 average moved without completion");
  ext2_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $changed(o_result[2].avg) |-> o_done[2])
    else $error("ext2 average moved without completion");
  depth_read_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_reg.re && i_reg.addr == ADDR_AVG_CFG) |=> o_reg_rvalid &&
      (o_reg_rdata[CFG_W-1:0] == $past(cfg)) && (o_reg_rdata[DATA_W-1:CFG_W] == '0))
    else $error("averaging config read back wrong");
  limit_width_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_reg_rvalid |-> (o_reg_rdata[DATA_W-1:TEMP_W] == '0))
    else $error("limit read shows bits above twelve");
  read_answer_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_reg.re |=> o_reg_rvalid)
    else $error("register read got no answer");
  flag_spare_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_result[0].flags[0] | o_result[1].flags[0] | o_result[2].flags[0]) == 1'b0)
    else $error("unused flag bit set");

endmodule
`default_nettype wire

// [bench/temp_sample_src.sv]
// sensor-side model that streams a burst of equal samples
`timescale 1ns/1ps
`default_nettype none
module temp_sample_src
  import temp_limit_monitor_pkg::*;
(
  input  wire logic                            i_core_clk,
  input  wire logic                            i_start,
  input  wire logic [5:0]                      i_count,
  input  wire logic [NUM_CHAN-1:0]             i_sel,
  input  wire logic [TEMP_W-1:0]               i_value,
  output var  logic [NUM_CHAN-1:0]             o_valid = '0,
  output var  logic [NUM_CHAN-1:0][TEMP_W-1:0] o_sample = '0
);
  logic [5:0] left = '0;
  logic       go;
  // start is sampled at the edge, before the bench moves it
  always @(posedge i_core_clk) begin
    go = i_start;
    #1;
    if (go) left = i_count;
    if (left != 6'h00) begin
      o_valid  = i_sel;
      o_sample = {NUM_CHAN{i_value}};
      left--;
    end else begin
      o_valid  = '0;
      o_sample = ~o_sample; // idle data is never stale
    end
  end
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// register and averaging tests for the temperature limit monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import temp_limit_monitor_pkg::*;
  logic                            clk = 0, rst = 1, start = 0;
  reg_req_s                        req = '0;
  logic [DATA_W-1:0]               rdata;
  logic                            rvalid;
  logic [NUM_CHAN-1:0]             en = '1, sel = '0, valid, done;
  logic [NUM_CHAN-1:0][TEMP_W-1:0] smp;
  chan_result_s [NUM_CHAN-1:0]     res;
  logic [5:0]                      cnt = '0;
  logic [TEMP_W-1:0]               val = '0;
  logic [FLAG_W-1:0]               exp_flags;
  logic [TEMP_W-1:0]               vals [4] = '{12'h020, 12'hfe0, 12'h010, 12'hff0};
  int                              fails = 0, total_checks = 0, cyc = 0, k;
  always #2.5 clk = ~clk;
  temp_limit_monitor uut (.i_core_clk(clk), .i_rst(rst), .i_reg(req), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_chan_en(en), .i_sample_valid(valid), .i_sample(smp),
    .o_result(res), .o_done(done));
  temp_sample_src src (.i_core_clk(clk), .i_start(start), .i_count(cnt), .i_sel(sel),
    .i_value(val), .o_valid(valid), .o_sample(smp));
  // ==========================================================
  // tasks
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk); #1 req = '{1'b1, 1'b0, a, d};
    @(posedge clk); #1 req = '0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk); #1 req = '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk); #1 req = '0;
    chk({15'h0000, rvalid}, 16'h0001);
    chk(rdata, e);
  endtask
  task automatic run(input int c, input int nn, input int lim);
    @(posedge clk); #1 cnt = 6'(nn); start = 1;
    @(posedge clk); #1 start = 0;
    k = 0;
    while (done[c] !== 1'b1 && k < lim) begin
      @(posedge clk); #1;
      k++;
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    #1 rst = 0;
    rd(3'h0, 16'h0000);
    rd(3'h1, 16'h07ff);
    rd(3'h2, 16'h0800);
    wr(3'h7, 16'hffff);
    rd(3'h7, 16'h0000);
    for (int c = 0; c < NUM_CHAN; c++) begin
      wr(3'(1 + 2 * c), 16'hf010);
      wr(3'(2 + 2 * c), 16'hfff0);
      rd(3'(1 + 2 * c), 16'h0010);
      rd(3'(2 + 2 * c), 16'h0ff0);
    end
    for (int c = 0; c < NUM_CHAN; c++) begin
      for (int d = 0; d < 4; d++) begin
        wr(3'h0, 16'(d << (2 * c)));
        rd(3'h0, 16'(d << (2 * c)));
        val = vals[d];
        sel = 3'(1 << c);
        run(c, 4 << d, 60);
        // k counts edges from the first sample edge to the one that closes the block
        chk(16'(k), 16'(4 << d));
        chk({4'h0, res[c].avg}, {4'h0, val});
        exp_flags = {$signed(val) > $signed(12'h010), $signed(val) < $signed(12'hff0), 1'b0};
        chk(16'(res[c].flags), 16'(exp_flags));
      end
    end
    // a disabled channel drops its flags and ignores samples
    wr(3'h0, 16'h0000);
    val = vals[0];
    sel = 3'h1;
    run(0, 4, 60);
    chk({13'h0000, res[0].flags}, 16'h0004);
    en = '0;
    repeat (2) @(posedge clk);
    #1;
    chk({13'h0000, res[0].flags}, 16'h0000);
    run(0, 4, 40);
    chk(16'(k), 16'd40);
    summarize();
  end
endmodule
`default_nettype wire
